// >>> src/fhts_tx.sv
// Purpose: Transmitting end: generates sequence numbers and builds headers.
// Assumes: The user holds a request until busy falls.
// Notes: Counters live in an array indexed by endpoint and flow kind.
//
// Operation
// [RL1] Each endpoint has its own sequence counter; the code keys it on endpoint_identifier[3:0] only.
// [RL2] Transmitter generates, receiver only checks sequence.
// [RL3] Downlink and uplink control counters kept separate.
// [RL4] Direction flag one downlink, zero uplink.
// [RL5] Optional shared control counter at baseband unit.
// [RL6] Message identifier: sequence, last flag, subsequence.
// [RL7] Header order: subtype, flow, length, order info.
// [RL8] Default sub-types 128 to 131.
// [RL9] Sub-types 132 to 191 unmapped, code 0xffff.
// [RL10] Mapping pairs company code with payload code.
// [RL11] Mapping fixed by default in this node.
// [RL12] Flow identifier within 0 to 0xfe.
// [RL13] Length counts payload octets after header.
// [RL14] Four flow kinds wrap independently.
// [RL15] Control messages: subsequence zero, last flag one.
// [RL16] Order info holds endpoint, sequence, flag, subsequence.
// [RL17] Receiver flags sequence gaps and disorder.
`timescale 1ns/100ps
`include "fhts_defs.svh"
module fhts_tx
  import fhts_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // User request.
  input wire logic req,
  input wire logic req_ctrl,
  input wire logic traffic_direction_flag,
  input wire logic req_concat,
  input wire logic [15:0] endpoint_identifier,
  input wire logic [7:0] req_flow_id,
  input wire logic [15:0] req_length,
  input wire logic [6:0] req_subseq,
  input wire logic req_last_frag,
  input wire logic shared_ctrl_seq,
  output logic busy,
  output logic req_error,
  // Link side.
  fhts_link_if.tx link
);
  // ------------------------------------------------------------
  // Sequence counters
  // ------------------------------------------------------------
  logic [7:0] seq_mem [0:63];
  logic [63:0] hdr;
  logic [3:0] idx;
  logic active;
  // Sharing folds uplink-describing control onto the downlink counter.
  wire logic eff_dir = (req_ctrl && shared_ctrl_seq) ? `FHTS_DIR_DL
                     : traffic_direction_flag; // RL5 RL4
  wire logic [5:0] slot = fhts_slot(endpoint_identifier, req_ctrl, eff_dir); // RL1 RL3 RL14
  wire logic [7:0] sub = req_ctrl ? (req_concat ? `FHTS_SUB_CCAT : `FHTS_SUB_CNCAT)
                       : (req_concat ? `FHTS_SUB_UCAT : `FHTS_SUB_UNCAT); // RL8 RL11
  wire logic bad_flow = (req_flow_id == `FHTS_FLOW_CTRL); // RL12
  wire logic [6:0] subseq = req_ctrl ? 7'h00 : req_subseq; // RL15
  wire logic last = req_ctrl ? 1'b1 : req_last_frag; // RL15
  // A sweep zeroes every counter after reset; requests wait behind busy until it ends.
  logic [6:0] clr;
  wire logic sweeping = !clr[6];
  wire logic take = req && !busy && !bad_flow;
  // Sub-type, flow, length, then order info with endpoint first.
  wire logic [63:0] next_hdr = {sub, req_flow_id, req_length, endpoint_identifier,
                                seq_mem[slot], last, subseq}; // RL7 RL6 RL16 RL13
  assign busy = active || sweeping;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
      idx <= 4'h0;
      hdr <= 64'h0;
      req_error <= 1'b0;
    end else begin
      req_error <= req && !busy && bad_flow;
      if (take) begin
        active <= 1'b1;
        idx <= 4'h0;
        hdr <= next_hdr;
      end else if (active) begin
        idx <= idx + 4'h1;
        hdr <= {hdr[55:0], 8'h00};
        if (idx == `FHTS_HDR_BYTES - 4'h1) begin
          active <= 1'b0;
        end
      end
    end
  end
  // Counters advance once per message; fragments share one number.
  always_ff @(posedge sys_clk) begin
    if (sweeping) begin
      seq_mem[clr[5:0]] <= 8'h00;
    end else if (take && last) begin
      seq_mem[slot] <= seq_mem[slot] + 8'h01; // RL2 RL14
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clr <= 7'h00;
    end else if (!clr[6]) begin
      clr <= clr + 7'h01;
    end
  end
  // ------------------------------------------------------------
  // Link drive
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.valid <= 1'b0;
      link.start <= 1'b0;
      link.data <= 8'h00;
    end else begin
      link.valid <= active;
      link.start <= active && (idx == 4'h0);
      link.data <= hdr[63:56];
    end
  end
endmodule

// >>> src/fhts_defs.svh
// Purpose: Constants for the fronthaul transport header and sequence block.
// Assumes: Octet 1 of a header is sent first on the byte stream.
// Notes: Included by bare name.
`ifndef FHTS_DEFS_SVH
`define FHTS_DEFS_SVH
`define FHTS_DIR_DL 1'b1
`define FHTS_DIR_UL 1'b0
`define FHTS_SUB_UNCAT 8'h80
`define FHTS_SUB_UCAT 8'h81
`define FHTS_SUB_CNCAT 8'h82
`define FHTS_SUB_CCAT 8'h83
`define FHTS_SUB_MAX 8'hbf
`define FHTS_MAP_UNMAPPED 16'hffff
`define FHTS_FLOW_MAX 8'hfe
`define FHTS_FLOW_CTRL 8'hff
`define FHTS_HDR_BYTES 4'h8
`define FHTS_EP_WIDTH 16
`define FHTS_EP_SLOTS 16
`endif

// >>> src/fhts_pkg.sv
// Purpose: Types shared by both ends of the transport header link.
// Assumes: Nothing beyond the defines header.
// Notes: Flow kinds index the per endpoint counter banks.
package fhts_pkg;
  typedef enum logic [1:0] {
    FHTS_U_DL = 2'h0,
    FHTS_U_UL = 2'h1,
    FHTS_C_DL = 2'h2,
    FHTS_C_UL = 2'h3
  } fhts_kind_t;
  typedef struct packed {
    logic [7:0] subtype;
    logic [7:0] flow_id;
    logic [15:0] length;
    logic [15:0] endpoint_identifier;
    logic [7:0] seq;
    logic last_frag;
    logic [6:0] subseq;
  } fhts_hdr_t;
  // Counter bank index: endpoint low bits and flow kind.
  function automatic logic [5:0] fhts_slot(input logic [15:0] ep, input logic ctrl,
                                           input logic dir);
    fhts_slot = {ep[3:0], ctrl, ~dir};
  endfunction
  // Payload structure code for a sub-type, 16'hffff when unmapped.
  function automatic logic [15:0] fhts_map(input logic [7:0] sub);
    if (sub == 8'h80) begin
      fhts_map = 16'h0001;
    end else if (sub == 8'h81) begin
      fhts_map = 16'h0002;
    end else if (sub == 8'h82) begin
      fhts_map = 16'h0003;
    end else if (sub == 8'h83) begin
      fhts_map = 16'h0004;
    end else begin
      fhts_map = 16'hffff;
    end
  endfunction
endpackage

// >>> src/fhts_link_if.sv
// Purpose: Byte stream carrying transport headers between two fronthaul nodes.
// Assumes: One byte per cycle when valid is high; no back pressure.
// Notes: Start marks octet 1 of a header.
`timescale 1ns/100ps
interface fhts_link_if;
  logic valid;
  logic start;
  logic [7:0] data;
  modport tx (output valid, output start, output data);
  modport rx (input valid, input start, input data);
endinterface

// >>> src/fhts_rx.sv
// Purpose: Receiving end: parses headers and checks sequence numbers.
// Assumes: Headers arrive as eight back to back bytes.
// Notes: The first message of each flow after reset sets the expectation.
`timescale 1ns/100ps
`include "fhts_defs.svh"
module fhts_rx
  import fhts_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration.
  input wire logic shared_ctrl_seq,
  // Link side.
  fhts_link_if.rx link,
  // Parsed header.
  output logic hdr_valid,
  output fhts_hdr_t hdr,
  output logic [15:0] payload_code,
  output logic hdr_is_ctrl,
  output logic traffic_direction_flag,
  output logic unmapped,
  output logic bad_flow,
  output logic seq_error
);
  // ------------------------------------------------------------
  // Header assembly
  // ------------------------------------------------------------
  logic [63:0] sr;
  logic [3:0] cnt;
  logic [7:0] exp_mem [0:63];
  logic [63:0] seen;
  wire logic [63:0] next_sr = {sr[55:0], link.data};
  wire logic done = link.valid && (cnt == `FHTS_HDR_BYTES - 4'h1 || link.start) &&
                    !(link.start && cnt != 4'h0) && (cnt == `FHTS_HDR_BYTES - 4'h1);
  wire fhts_hdr_t h = next_sr; // RL7 RL6 RL16
  wire logic ctrl = (h.subtype == `FHTS_SUB_CNCAT) || (h.subtype == `FHTS_SUB_CCAT);
  // Direction is not in this header; controls describing both share a slot when shared.
  wire logic eff_dir = (ctrl && shared_ctrl_seq) ? `FHTS_DIR_DL : h.endpoint_identifier[15]; // RL5
  wire logic [5:0] slot = fhts_slot(h.endpoint_identifier, ctrl, eff_dir); // RL1 RL3 RL14
  wire logic gap = seen[slot] && (h.seq != exp_mem[slot]); // RL17 RL2
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sr <= 64'h0;
      cnt <= 4'h0;
    end else if (link.valid) begin
      sr <= next_sr;
      cnt <= link.start ? 4'h1 : (done ? 4'h0 : cnt + 4'h1);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (done && h.last_frag) begin
      exp_mem[slot] <= h.seq + 8'h01; // RL14
    end else if (done && !seen[slot]) begin
      exp_mem[slot] <= h.seq;
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= 64'h0;
      hdr_valid <= 1'b0;
      hdr <= '0;
      payload_code <= 16'h0;
      hdr_is_ctrl <= 1'b0;
      traffic_direction_flag <= 1'b0;
      unmapped <= 1'b0;
      bad_flow <= 1'b0;
      seq_error <= 1'b0;
    end else begin
      hdr_valid <= done;
      if (done) begin
        seen[slot] <= 1'b1;
        hdr <= h; // RL13
        payload_code <= fhts_map(h.subtype); // RL9 RL10 RL8
        unmapped <= fhts_map(h.subtype) == `FHTS_MAP_UNMAPPED; // RL9
        hdr_is_ctrl <= ctrl;
        traffic_direction_flag <= eff_dir; // RL4
        bad_flow <= h.flow_id > `FHTS_FLOW_MAX ||
                    (ctrl && (h.subseq != 7'h00 || !h.last_frag)); // RL12 RL15
        seq_error <= gap;
      end
    end
  end
endmodule

// >>> testbench/fhts_assertions.sv
// Purpose: Framing and field checks on the transport header byte stream.
// Assumes: Inputs are the link interface signals between the two ends.
// Notes: The link carries no direction, so sequence order is judged by the bench.
`timescale 1ns/100ps
module fhts_assertions (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link.
  input wire logic valid,
  input wire logic start,
  input wire logic [7:0] data
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_frame;
    valid [*8] ##1 !valid;
  endsequence
  sequence s_ctrl_head;
    start && data[7:1] == 7'h41;
  endsequence
  a_frame_length: assert property (start |-> s_frame)
    else $error("header is not eight bytes followed by a gap");
  a_start_once: assert property (start |=> !start [*7])
    else $error("start marked inside a header");
  a_start_valid: assert property (start |-> valid)
    else $error("start without valid");
  a_rise_start: assert property ($rose(valid) |-> start)
    else $error("header opened without start");
  a_subtype_range: assert property (start |-> data inside {[8'h80:8'h83]})
    else $error("sub-type outside the defaults");
  a_flow_legal: assert property (start |=> data != 8'hff)
    else $error("reserved flow identifier sent");
  // Control messages are never split, so the last octet is fixed.
  a_ctrl_order: assert property (s_ctrl_head |-> ##7 data == 8'h80)
    else $error("control message with subsequence or flag wrong");
  a_ctrl_seq_byte: assert property (s_ctrl_head |-> ##6 valid ##1 valid)
    else $error("control header lost its identifier octets");
endmodule

// >>> testbench/test_fronthaul_transport_header_seq.sv
// Purpose: Self-checking bench joining transmit and receive ends over the link.
// Assumes: Every counter slot starts at zero once the transmit sweep has ended.
// Notes: A second receiver is fed faulty headers by the bench itself.
`timescale 1ns/100ps
module test_fronthaul_transport_header_seq import fhts_pkg::*;;
  logic sys_clk = 0;
  logic reset_n = 0;
  logic req = 0;
  logic sh = 0;
  logic [34:0] rq = '0;
  logic busy, req_error, hv, hc, hd, um, bf, se, hv2, um2, bf2, se2;
  logic [15:0] pc, pc2;
  logic [63:0] cap = '0;
  fhts_hdr_t hdr, hdr2;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] nx [64] = '{default: 8'h00};
  fhts_link_if link();
  fhts_link_if l2();
  fhts_tx i_fhts_tx(.sys_clk, .reset_n, .req, .req_ctrl(rq[34]), .traffic_direction_flag(rq[33]),
    .req_concat(rq[32]), .endpoint_identifier(rq[31:16]), .req_flow_id(rq[15:8]),
    .req_length({rq[15:8], rq[23:16]}), .req_subseq(rq[7:1]), .req_last_frag(rq[0]),
    .shared_ctrl_seq(sh), .busy, .req_error, .link(link));
  fhts_rx i_fhts_rx(.sys_clk, .reset_n, .shared_ctrl_seq(sh), .link(link), .hdr_valid(hv), .hdr,
    .payload_code(pc), .hdr_is_ctrl(hc), .traffic_direction_flag(hd), .unmapped(um),
    .bad_flow(bf), .seq_error(se));
  fhts_rx i_fhts_rx2(.sys_clk, .reset_n, .shared_ctrl_seq(1'b0), .link(l2), .hdr_valid(hv2),
    .hdr(hdr2), .payload_code(pc2), .hdr_is_ctrl(), .traffic_direction_flag(),
    .unmapped(um2), .bad_flow(bf2), .seq_error(se2));
  fhts_assertions i_chk(.sys_clk, .reset_n, .valid(link.valid), .start(link.start),
    .data(link.data));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    l2.valid = 0;
    l2.start = 0;
    l2.data = 8'h00;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (link.valid === 1'b1) cap <= {cap[55:0], link.data};
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_hdr(input bit two);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((two ? hv2 : hv) !== 1'b1 && n < 30);
    chk("hdr_valid", 1, two ? hv2 : hv);
  endtask
  // The request stands until an edge at which busy is sampled low.
  task automatic drv(input logic [34:0] v);
    @(posedge sys_clk);
    req <= 1;
    rq <= v;
    do begin
      @(posedge sys_clk);
    end while (busy !== 1'b0);
    req <= 0;
  endtask
  task automatic send(input logic c, d, k, input logic [15:0] e, input logic [7:0] f,
    input logic [6:0] s, input logic l);
    logic [5:0] sl;
    logic [63:0] x;
    drv({c, d, k, e, f, s, l});
    sl = {e[3:0], c, (c && sh) ? 1'b1 : d};
    @(negedge sys_clk);
    chk("busy", 1, busy);
    wait_hdr(0);
    x = {8'h80 + {c, k}, f, f, e[7:0], e, nx[sl], c ? 8'h80 : {l, s}};
    chk("wire", x, cap);
    chk("parsed", x, hdr);
    chk("code", 16'h0001 + {c, k}, pc);
    chk("flags", {c, 2'b00}, {hc, um, bf});
    chk("seq", nx[sl], hdr.seq);
    chk("dir", {d | (c && sh), 1'b0}, {hd, se});
    nx[sl] = nx[sl] + {7'h00, c | l};
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_kinds();
    for (int i = 0; i < 8; i++) send(i[2], i[1], i[0], {i[1], 15'h3}, 8'(i * 37), 7'(i), 1);
  endtask
  task automatic t_seq();
    for (int j = 0; j < 260; j++) begin
      send(0, 1, 0, 16'h8005, 8'hfe, 7'h00, 1);
      if (j < 4) begin
        send(0, 0, 0, 16'h0005, 8'h00, 7'h00, 1);
        send(1, 1, 1, 16'h8005, 8'h10, 7'h00, 1);
        send(1, 0, 0, 16'h0005, 8'h11, 7'h00, 1);
        send(0, 1, 0, 16'h8006, 8'h12, 7'h00, 1);
      end
    end
  endtask
  task automatic t_frag();
    for (int i = 0; i < 4; i++) send(0, 0, 1, 16'h000a, 8'h01, 7'(i % 3), i > 1);
  endtask
  task automatic t_refuse();
    int n;
    n = 0;
    drv({3'b010, 16'h8005, 8'hff, 7'h00, 1'b1});
    @(negedge sys_clk);
    chk("req_error", 1, req_error);
    repeat (12) begin
      @(negedge sys_clk);
      if (link.valid !== 1'b0 || busy !== 1'b0) n++;
    end
    chk("refused_bytes", 0, n);
    send(0, 1, 0, 16'h8005, 8'h00, 7'h00, 1);
  endtask
  task automatic t_shared();
    @(posedge sys_clk);
    sh <= 1;
    for (int i = 0; i < 3; i++) send(1, i[0], 0, 16'h0009, 8'h20, 7'h00, 1);
    @(posedge sys_clk);
    sh <= 0;
  endtask
  task automatic t_bad(input logic [63:0] b, input logic [2:0] fx, input logic [15:0] code);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      l2.valid <= 1;
      l2.start <= (i == 0);
      l2.data <= b[63 - 8 * i -: 8];
    end
    @(posedge sys_clk);
    l2.valid <= 0;
    l2.data <= ~b[7:0];
    wait_hdr(1);
    chk("rx_hdr", b, hdr2);
    chk("rx_flags", fx, {um2, bf2, se2});
    chk("rx_code", code, pc2);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1;
    t_kinds();
    t_seq();
    t_frag();
    t_refuse();
    t_shared();
    t_bad(64'h90ff000400010000, 3'b110, 16'hffff);
    t_bad(64'h8201001000020003, 3'b010, 16'h0003);
    t_bad(64'h8001000080020580, 3'b000, 16'h0001);
    t_bad(64'h8001000080020780, 3'b001, 16'h0001);
    close_out();
  end
endmodule
